// File: fpw_pkg.sv
package fpw_pkg;
  // Crystal time base and clock rate
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned XTAL_HZ        = 32768;
  // Expiry interval, in milliseconds of crystal time
  localparam int unsigned EXPIRY_MS      = 1500;
  localparam int unsigned EXPIRY_TICKS   = (XTAL_HZ * EXPIRY_MS) / 1000;
  // Early warning lead, milliseconds
  localparam int unsigned WARN_MS        = 1;
  localparam int unsigned WARN_TICKS     = (XTAL_HZ * WARN_MS + 999) / 1000;
  // Relaunch delay after expiry, crystal cycles (about 125 ms)
  localparam int unsigned RELAUNCH_TICKS = 4100;
  localparam int unsigned CNT_W          = 16;
  localparam logic [15:0] RESTART_ADDR   = 16'h0000;
  typedef enum logic [1:0] {FPW_RUN, FPW_HOLD} fpw_state_e;
endpackage

// File: fpw_tick_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Turns the crystal oscillator level into a one-cycle tick per rising edge
module fpw_tick_sync (
  input  wire logic clock_in,   // System clock
  input  wire logic reset_in,   // Synchronous reset
  input  wire logic xtal_in,    // Crystal oscillator level
  output logic      tick_out    // One pulse per crystal cycle
);
  logic s1_reg, s2_reg, s3_reg, tick_reg;
  logic s1_next, s2_next, s3_next, tick_next;

  always_comb begin
    s1_next   = xtal_in;
    s2_next   = s1_reg;
    s3_next   = s2_reg;
    tick_next = s2_reg & ~s3_reg;
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      s1_reg   <= 1'b0;
      s2_reg   <= 1'b0;
      s3_reg   <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      s1_reg   <= s1_next;
      s2_reg   <= s2_next;
      s3_reg   <= s3_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_out = tick_reg;
endmodule
`default_nettype wire

// File: fpw_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Expiry issues a chip reset that keeps wake-up state of I/O RAM.
// - Processor relaunches at address 0x0000 after 4100 crystal cycles.
// - Every expiry sets the expiry flag, kept in display mode, lost in sleep.
// - Flag stays until firmware clears it, the external reset pin asserts or sleep mode is active.
// - No register bit can stop the watchdog; only the debugger and a low internal wake level hold it.
// - Debugger enable holds the watchdog inactive.
// - Writing one to the refresh bit restarts the count from zero.
// - Count is held reset while the internal wake level is low.
// - With warning enabled, interrupt rises about 1 ms before the reset.
module fpw_watchdog #(
  parameter int unsigned EXPIRY_TICKS   = fpw_pkg::EXPIRY_TICKS,
  parameter int unsigned WARN_TICKS     = fpw_pkg::WARN_TICKS,
  parameter int unsigned RELAUNCH_TICKS = fpw_pkg::RELAUNCH_TICKS
) (
  input  wire logic        clock_in,                   // System clock, 25 MHz
  input  wire logic        reset_in,                   // Synchronous reset, active high
  input  wire logic        xtal_in,                    // Crystal oscillator level
  input  wire logic        reset_pin_in,               // External reset pin, active high
  input  wire logic        watchdog_refresh_bit_in,    // Write-one pulse of refresh bit
  input  wire logic        early_warning_irq_enable_in, // Early warning enable
  input  wire logic        debugger_enable_in,         // Debugger holds watchdog off
  input  wire logic        wake_in,                    // Internal wake level
  input  wire logic        sleep_mode_in,              // Deepest sleep mode active
  input  wire logic        flag_clear_in,              // Firmware clears expiry flag
  output logic             chip_reset_out,             // Watchdog chip reset request
  output logic             keep_wake_ram_out,          // I/O RAM takes wake-up state
  output logic             cpu_launch_out,             // Pulse: start processor
  output logic [15:0]      launch_addr_out,            // Start address
  output logic             early_warning_irq_out,      // Warning interrupt pulse
  output logic             watchdog_expiry_flag_out    // Expiry status flag
);
  ////////////////////////////////////////////////////////////////////////////
  logic tick;

  fpw_tick_sync u_tick (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .xtal_in  (xtal_in),
    .tick_out (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Local copy keeps the size casts free of scoped names
  localparam int unsigned CW = fpw_pkg::CNT_W;
  localparam logic [CW-1:0] EXP_LAST  = CW'(EXPIRY_TICKS - 1);
  localparam logic [CW-1:0] WARN_AT   = CW'(EXPIRY_TICKS - WARN_TICKS);
  localparam logic [CW-1:0] RELA_LAST = CW'(RELAUNCH_TICKS - 1);

  fpw_pkg::fpw_state_e     state_reg, state_next;
  logic [fpw_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic                    warned_reg, warned_next;
  logic                    rst_reg, rst_next;
  logic                    launch_reg, launch_next;
  logic                    irq_reg, irq_next;
  logic                    flag_reg, flag_next;
  logic                    held_off;
  logic                    expire;

  // Only the debugger or a low wake level stops counting; no firmware bit does
  assign held_off = debugger_enable_in | ~wake_in;
  // Refresh in the expiry cycle wins, so a last-moment refresh is never lost
  assign expire   = (state_reg == fpw_pkg::FPW_RUN) & ~held_off & tick &
                    (cnt_reg == EXP_LAST) & ~watchdog_refresh_bit_in;

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    warned_next = warned_reg;
    rst_next    = rst_reg;
    launch_next = 1'b0;
    irq_next    = 1'b0;
    case (state_reg)
      fpw_pkg::FPW_RUN: begin
        if (held_off) begin
          cnt_next    = '0;
          warned_next = 1'b0;
        end else if (watchdog_refresh_bit_in) begin
          // A refresh after the warning still cancels the pending reset
          cnt_next    = '0;
          warned_next = 1'b0;
        end else if (expire) begin
          state_next  = fpw_pkg::FPW_HOLD;
          cnt_next    = '0;
          rst_next    = 1'b1;
          warned_next = 1'b0;
        end else if (tick) begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg == WARN_AT && !warned_reg) begin
            warned_next = 1'b1;
            irq_next    = early_warning_irq_enable_in;
          end
        end
      end
      // Relaunch delay ignores refresh and holds: the chip is already in reset
      fpw_pkg::FPW_HOLD: begin
        if (tick) begin
          if (cnt_reg == RELA_LAST) begin
            state_next  = fpw_pkg::FPW_RUN;
            cnt_next    = '0;
            rst_next    = 1'b0;
            launch_next = 1'b1;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
      end
      default: state_next = fpw_pkg::FPW_RUN;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_reg  <= fpw_pkg::FPW_RUN;
      cnt_reg    <= '0;
      warned_reg <= 1'b0;
      rst_reg    <= 1'b0;
      launch_reg <= 1'b0;
      irq_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      warned_reg <= warned_next;
      rst_reg    <= rst_next;
      launch_reg <= launch_next;
      irq_reg    <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag: set wins over firmware clear, reset pin and sleep, which otherwise clear it
  always_comb begin
    flag_next = flag_reg;
    if (expire) begin
      flag_next = 1'b1;
    end else if (reset_pin_in || sleep_mode_in || flag_clear_in) begin
      flag_next = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start address is registered so every output leaves a flip-flop
  logic [15:0] addr_reg, addr_next;

  always_comb begin
    addr_next = fpw_pkg::RESTART_ADDR;
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      addr_reg <= fpw_pkg::RESTART_ADDR;
    end else begin
      addr_reg <= addr_next;
    end
  end

  assign chip_reset_out           = rst_reg;
  assign keep_wake_ram_out        = rst_reg;
  assign cpu_launch_out           = launch_reg;
  assign launch_addr_out          = addr_reg;
  assign early_warning_irq_out    = irq_reg;
  assign watchdog_expiry_flag_out = flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  a_expiry_sets_flag: assert property (expire |=> watchdog_expiry_flag_out)
    else $error("expiry did not set flag");
  a_expiry_resets_chip: assert property (expire |=> chip_reset_out && keep_wake_ram_out)
    else $error("expiry did not reset chip");
  a_refresh_clears_cnt: assert property (
    state_reg == fpw_pkg::FPW_RUN && watchdog_refresh_bit_in |=> cnt_reg == '0)
    else $error("refresh did not restart count");
  a_debug_holds_off: assert property (
    debugger_enable_in && state_reg == fpw_pkg::FPW_RUN |=> !chip_reset_out && cnt_reg == '0)
    else $error("debugger did not hold watchdog");
  a_wake_low_holds: assert property (!wake_in && state_reg == fpw_pkg::FPW_RUN |=> cnt_reg == '0)
    else $error("low wake did not hold count");
  a_pin_clears_flag: assert property (reset_pin_in && !expire |=> !watchdog_expiry_flag_out)
    else $error("reset pin did not clear flag");
  a_flag_holds: assert property (
    watchdog_expiry_flag_out && !reset_pin_in && !sleep_mode_in && !flag_clear_in |=> watchdog_expiry_flag_out)
    else $error("flag dropped without clear");
  a_hold_keeps_reset: assert property (state_reg == fpw_pkg::FPW_HOLD |-> chip_reset_out)
    else $error("reset dropped during relaunch delay");
  // Pulses are judged against the state one edge earlier
  a_launch_after_hold: assert property (
    cpu_launch_out |-> $past(chip_reset_out) && !chip_reset_out && $past(cnt_reg) == RELA_LAST)
    else $error("launch without full delay");
  a_launch_from_zero: assert property (cpu_launch_out |-> launch_addr_out == fpw_pkg::RESTART_ADDR)
    else $error("launch address not zero");
  a_warn_needs_enable: assert property (
    early_warning_irq_out |-> $past(early_warning_irq_enable_in) && $past(cnt_reg) == WARN_AT)
    else $error("warning at wrong point");
  a_warn_off_quiet: assert property (!early_warning_irq_enable_in |=> !early_warning_irq_out)
    else $error("warning while disabled");
  a_warn_once: assert property (early_warning_irq_out |=> !early_warning_irq_out [*2])
    else $error("warning repeated");
  a_warn_per_interval: assert property (early_warning_irq_out |-> !$past(warned_reg))
    else $error("second warning in one interval");

  c_expiry:  cover property (expire);
  c_launch:  cover property (cpu_launch_out);
  c_warning: cover property (early_warning_irq_out);
  c_late_refresh: cover property (warned_reg && watchdog_refresh_bit_in);
  c_debug_hold: cover property (debugger_enable_in && state_reg == fpw_pkg::FPW_RUN);
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned EXP = 40;
  localparam int unsigned WRN = 4;
  localparam int unsigned REL = 10;
  logic        clock_in  = 1'b0;
  logic        reset_in  = 1'b1;
  logic        xtal_in   = 1'b0;
  logic        pin_in    = 1'b0;
  logic        ref_in    = 1'b0;
  logic        warn_en   = 1'b0;
  logic        dbg_in    = 1'b0;
  logic        wake_in   = 1'b1;
  logic        sleep_in  = 1'b0;
  logic        clear_in  = 1'b0;
  logic        chip_rst, keep_ram, launch, warn, flag;
  logic [15:0] addr;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          warn_seen = 0;
  int          launch_seen = 0;
  always #20 clock_in = ~clock_in;
  fpw_watchdog #(.EXPIRY_TICKS(EXP), .WARN_TICKS(WRN), .RELAUNCH_TICKS(REL)) dut_u (
    .clock_in(clock_in), .reset_in(reset_in), .xtal_in(xtal_in), .reset_pin_in(pin_in),
    .watchdog_refresh_bit_in(ref_in), .early_warning_irq_enable_in(warn_en),
    .debugger_enable_in(dbg_in), .wake_in(wake_in), .sleep_mode_in(sleep_in),
    .flag_clear_in(clear_in), .chip_reset_out(chip_rst), .keep_wake_ram_out(keep_ram),
    .cpu_launch_out(launch), .launch_addr_out(addr), .early_warning_irq_out(warn),
    .watchdog_expiry_flag_out(flag));
  // Pulses last one cycle, so they are counted at every falling edge, where they have settled
  always @(negedge clock_in) begin
    if (warn === 1'b1) warn_seen++;
    if (launch === 1'b1) launch_seen++;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (bad_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Eight clocks per crystal period, well above the three-clock sync delay
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge clock_in) xtal_in = 1'b1;
      repeat (4) @(negedge clock_in);
      xtal_in = 1'b0;
      repeat (3) @(negedge clock_in);
    end
  endtask
  // One-cycle pulse: 0 clear, 1 reset pin, 2 sleep, 3 refresh
  task automatic hit(input int w);
    @(negedge clock_in);
    clear_in = (w == 0);
    pin_in   = (w == 1);
    sleep_in = (w == 2);
    ref_in   = (w == 3);
    @(negedge clock_in);
    {clear_in, pin_in, sleep_in, ref_in} = 4'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_expire();
    warn_en = 1'b1;
    ticks(EXP);
    chk("warn", 16'h1, 16'(warn_seen));
    chk("chip_reset", 16'h1, 16'(chip_rst));
    chk("keep_ram", 16'h1, 16'(keep_ram));
    chk("flag", 16'h1, 16'(flag));
    ticks(REL - 1);
    hit(3);
    chk("held", 16'h1, 16'(chip_rst));
    chk("no_launch", 16'h0, 16'(launch_seen));
    ticks(1);
    chk("launch", 16'h1, 16'(launch_seen));
    chk("released", 16'h0, 16'(chip_rst));
    chk("addr", 16'h0000, addr);
    chk("warn_once", 16'h1, 16'(warn_seen));
    chk("flag_kept", 16'h1, 16'(flag));
  endtask
  task automatic t_clear();
    for (int w = 0; w < 3; w++) begin
      ticks(EXP + REL);
      chk("flag_set", 16'h1, 16'(flag));
      hit(w);
      chk("flag_clear", 16'h0, 16'(flag));
    end
  endtask
  // Reset checks fall two ticks after the first and third refresh, inside the reset that a lost refresh would cause
  task automatic t_refresh();
    int base;
    warn_en = 1'b0;
    base = warn_seen;
    ticks(EXP - 1);
    hit(3);
    ticks(2);
    chk("refreshed", 16'h0, 16'(chip_rst));
    ticks(EXP - 3);
    chk("no_expiry", 16'h0, 16'(chip_rst));
    chk("warn_off", 16'h0, 16'(warn_seen - base));
    hit(3);
    warn_en = 1'b1;
    ticks(EXP - 2);
    chk("warn_on", 16'h1, 16'(warn_seen - base));
    hit(3);
    ticks(2);
    chk("late_refresh", 16'h0, 16'(chip_rst));
    ticks(EXP - 3);
    chk("warn_per_interval", 16'h2, 16'(warn_seen - base));
    hit(3);
  endtask
  task automatic t_hold();
    dbg_in = 1'b1;
    ticks(EXP + 5);
    chk("debug_hold", 16'h0, 16'(chip_rst));
    dbg_in = 1'b0;
    wake_in = 1'b0;
    ticks(EXP + 5);
    chk("wake_hold", 16'h0, 16'(chip_rst));
    wake_in = 1'b1;
    ticks(EXP - 1);
    chk("count_zeroed", 16'h0, 16'(chip_rst));
    ticks(1);
    chk("still_runs", 16'h1, 16'(chip_rst));
    ticks(REL);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clock_in);
    @(negedge clock_in) reset_in = 1'b0;
    t_expire();
    t_clear();
    t_refresh();
    t_hold();
    complete_run();
  end
  // The full sequence needs well under 0.3 ms
  initial begin
    #1ms;
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
